// File: include/panel_pkg.sv
// package: register map, field positions, modes and carriers for the flat panel output stage
package panel_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_DITHER_CFG  = 8'h00;
	localparam logic [7:0] ADDR_SEQ_TIMING  = 8'h04;
	localparam logic [7:0] ADDR_SEQ_CFG     = 8'h08;
	localparam logic [7:0] ADDR_DISPLAY     = 8'h0C;
	localparam logic [7:0] ADDR_POWER_CTRL  = 8'h10;
	localparam logic [7:0] ADDR_DUP_STEP    = 8'h14;
	localparam logic [7:0] ADDR_MODE        = 8'h18;
	localparam logic [7:0] ADDR_STATUS      = 8'h1C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int DSTN_LEVELS_BIT = 5;
	localparam int TFT_DITH_LO     = 6;
	localparam int SEQ_TIME_LO     = 2;
	localparam int SEQ_HW_BIT      = 7;
	localparam int DISP_EN_BIT     = 0;
	localparam int PWR_LOGIC_BIT   = 0;
	localparam int PWR_CTLDATA_BIT = 1;
	localparam int PWR_BIAS_BIT    = 2;
	localparam int PWR_PANEL_BIT   = 3;
	localparam int PWR_BKLGT_BIT   = 4;
	localparam int DUP_W           = 10;
	localparam int SUM_W           = 11;
	localparam int CNT_W           = 4;

	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [9:0] RST_DUP     = 10'h000;
	localparam logic [3:0] FRAME_ONE   = 4'h1;
	localparam logic [1:0] TFT_DITH_4  = 2'h0;
	localparam logic [1:0] TFT_DITH_8  = 2'h1;

	typedef enum logic [2:0] {
		MODE_TFT_1P,
		MODE_TFT_2P12,
		MODE_TFT_2P18,
		MODE_DSTN16,
		MODE_DSTN24
	} panel_mode_e;

	typedef enum logic [1:0] {
		XMIT_DIRECT,
		XMIT_LVDS,
		XMIT_TMDS
	} xmit_e;

	// pixel carrier from the display pipeline
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} rgb_s;

	// panel pin group
	typedef struct packed {
		logic [35:0] data;
		logic        hsync;
		logic        vsync;
		logic        valid;
	} panel_bus_s;

endpackage

// File: src/panel_dither.sv
// dithering engines for dstn and tft panels
`timescale 1ns/1ns
module panel_dither (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         pix_en_i,
	input  wire logic         stn_i,
	input  wire logic         dstn_32_i,
	input  wire logic [1:0]   tft_mode_i,
	input  wire logic [2:0]   frame_i,
	input  wire logic [4:0]   x_i,
	input  wire logic [4:0]   y_i,
	input  wire panel_pkg::rgb_s pix_i,
	output panel_pkg::rgb_s   pix_o
);

	// ****************************************
	// threshold lookup
	// ****************************************
	// mixes position and frame into a 5-bit pattern index: 32 dstn, 8 tft patterns
	function automatic logic [4:0] thresh(input logic [4:0] x, input logic [4:0] y, input logic [2:0] f);
		thresh = {x[0] ^ y[1], y[0], x[1] ^ f[0], f[1] ^ y[2], f[2] ^ x[2]};
	endfunction

	// adds the fraction below the kept bits against the threshold, saturating
	function automatic logic [7:0] dith(input logic [7:0] c, input int keep, input logic [4:0] t);
		logic [8:0] s;
		logic [7:0] mask;
		s = 9'h000;
		mask = 8'hFF << (8 - keep);
		s = {1'b0, c} + {1'b0, (8'(t) << 3) >> keep};
		if (s[8])
			dith = mask;
		else
			dith = s[7:0] & mask;
	endfunction

	logic [4:0] t;
	assign t = thresh(x_i, y_i, frame_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pix_o <= '0;
		end else if (pix_en_i) begin
			if (stn_i) begin
				pix_o.red   <= dith(pix_i.red,   dstn_32_i ? 5 : 4, t);
				pix_o.green <= dith(pix_i.green, dstn_32_i ? 5 : 4, t);
				pix_o.blue  <= dith(pix_i.blue,  dstn_32_i ? 5 : 4, t);
			end else if (tft_mode_i == panel_pkg::TFT_DITH_4 || tft_mode_i == panel_pkg::TFT_DITH_8) begin
				pix_o.red   <= dith(pix_i.red,   (tft_mode_i == panel_pkg::TFT_DITH_4) ? 6 : 5, {t[4:2], 2'h0});
				pix_o.green <= dith(pix_i.green, (tft_mode_i == panel_pkg::TFT_DITH_4) ? 6 : 5, {t[4:2], 2'h0});
				pix_o.blue  <= dith(pix_i.blue,  (tft_mode_i == panel_pkg::TFT_DITH_4) ? 6 : 5, {t[4:2], 2'h0});
			end else begin
				pix_o <= pix_i;
			end
		end
	end

endmodule

// File: src/panel_power_seq.sv
// panel power sequencer: hardware steps and software pass-through
`timescale 1ns/1ns
module panel_power_seq (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       hw_mode_i,
	input  wire logic       disp_en_i,
	input  wire logic [1:0] interval_i,
	input  wire logic [3:0] sw_power_i,
	input  wire logic       frame_tick_i,
	output logic            panel_logic_power_en_o,
	output logic            ctl_data_en_o,
	output logic            panel_bias_power_en_o,
	output logic            panel_enable_out_o,
	output logic            busy_o
);

	typedef enum logic [2:0] {S_OFF, S_UP1, S_UP2, S_UP3, S_ON, S_DN1, S_DN2, S_DN3} seq_e;

	seq_e                       state;
	logic [panel_pkg::CNT_W-1:0] frames;
	logic [panel_pkg::CNT_W-1:0] span;
	logic [3:0]                 hw_out;
	logic                       done;
	logic                       running;

	// 1, 2, 4 or 8 frames
	assign span = panel_pkg::FRAME_ONE << interval_i;
	assign done = frame_tick_i && (frames == span - panel_pkg::FRAME_ONE);
	assign running = (state != S_OFF) && (state != S_ON);
	// a pending toggle counts as busy so a second one is refused
	assign busy_o  = running || (hw_mode_i && (disp_en_i != (state == S_ON)));

	// ****************************************
	// frame counter
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || !running || done)
			frames <= '0;
		else if (frame_tick_i)
			frames <= frames + panel_pkg::FRAME_ONE;
	end

	// ****************************************
	// sequence state
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= S_OFF;
		end else if (!hw_mode_i) begin
			state <= disp_en_i ? S_ON : S_OFF;
		end else begin
			case (state)
				// start on a frame boundary so the first interval is whole
				S_OFF: if (disp_en_i && frame_tick_i) state <= S_UP1;
				S_UP1: if (done) state <= S_UP2;
				S_UP2: if (done) state <= S_UP3;
				S_UP3: if (done) state <= S_ON;
				S_ON:  if (!disp_en_i && frame_tick_i) state <= S_DN1;
				S_DN1: if (done) state <= S_DN2;
				S_DN2: if (done) state <= S_DN3;
				S_DN3: if (done) state <= S_OFF;
				default: state <= S_OFF;
			endcase
		end
	end

	// on: panel enable, bias, control/data, logic power; off runs the other way
	always_comb begin
		case (state)
			S_UP1:   hw_out = 4'b1000;
			S_UP2:   hw_out = 4'b1100;
			S_UP3:   hw_out = 4'b1110;
			S_ON:    hw_out = 4'b1111;
			S_DN1:   hw_out = 4'b1110;
			S_DN2:   hw_out = 4'b1100;
			S_DN3:   hw_out = 4'b1000;
			default: hw_out = 4'b0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			panel_enable_out_o     <= 1'b0;
			panel_bias_power_en_o  <= 1'b0;
			ctl_data_en_o          <= 1'b0;
			panel_logic_power_en_o <= 1'b0;
		end else if (hw_mode_i) begin
			panel_enable_out_o     <= hw_out[3];
			panel_bias_power_en_o  <= hw_out[2];
			ctl_data_en_o          <= hw_out[1];
			panel_logic_power_en_o <= hw_out[0];
		end else begin
			panel_enable_out_o     <= sw_power_i[panel_pkg::PWR_PANEL_BIT];
			panel_bias_power_en_o  <= sw_power_i[panel_pkg::PWR_BIAS_BIT];
			ctl_data_en_o          <= sw_power_i[panel_pkg::PWR_CTLDATA_BIT];
			panel_logic_power_en_o <= sw_power_i[panel_pkg::PWR_LOGIC_BIT];
		end
	end

endmodule

// File: src/flat_panel_power_dither_iface.sv
// flat panel output stage: registers, line duplication, dithering, power sequencing, pin mapping
// Contract
// - step added per line, sum reset
// - dstn dither, 32 patterns, 16/32 levels
// - tft dither, 8 patterns, 4/8/off
// - select bit picks hardware or software power
// - display enable toggle runs hardware sequence
// - interval field gives 1,2,4,8 frames
// - backlight independent of the sequencer
// - 24-bit tft lanes red, green, blue
// - 36-bit mode upper 12 on shared pins
// - dual-scan upper 23..12, lower 11..0
// - tft drives syncs, qualifier, pixel clock
// - transmitter order; stn uses serializer clock
`timescale 1ns/1ns
module flat_panel_power_dither_iface (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  pix_en_i,
	input  wire panel_pkg::rgb_s       pix_a_i,
	input  wire panel_pkg::rgb_s       pix_b_i,
	input  wire logic                  hsync_i,
	input  wire logic                  vsync_i,
	input  wire logic                  active_i,
	input  wire logic                  line_end_i,
	input  wire logic                  row_end_i,
	input  wire logic                  text_mode_i,
	input  wire logic [4:0]            x_i,
	input  wire logic [4:0]            y_i,
	input  wire logic                  serializer_clock_i,
	output panel_pkg::panel_bus_s      panel_o,
	output logic                       panel_shift_clock_o,
	output logic                       xmit_clock_o,
	output logic                       dup_line_o,
	output logic                       panel_enable_out_o,
	output logic                       panel_logic_power_en_o,
	output logic                       panel_bias_power_en_o,
	output logic                       backlight_ctrl_o
);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]  panel_dither_cfg;
	logic [7:0]  panel_seq_timing;
	logic [7:0]  panel_seq_cfg;
	logic [7:0]  panel_display_ctrl;
	logic [7:0]  panel_power_ctrl;
	logic [9:0]  line_dup_step;
	logic [7:0]  mode_reg;
	logic        wr;
	logic        busy;
	logic        disp_req;
	logic        ctl_data_en;
	logic [31:0] next_rdata;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

	// writes one byte lane register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			panel_dither_cfg   <= panel_pkg::RST_BYTE;
			panel_seq_timing   <= panel_pkg::RST_BYTE;
			panel_seq_cfg      <= panel_pkg::RST_BYTE;
			panel_power_ctrl   <= panel_pkg::RST_BYTE;
			mode_reg           <= panel_pkg::RST_BYTE;
		end else if (wr) begin
			case (wb_adr_i)
				panel_pkg::ADDR_DITHER_CFG: panel_dither_cfg <= wb_dat_i[7:0];
				panel_pkg::ADDR_SEQ_TIMING: panel_seq_timing <= wb_dat_i[7:0];
				panel_pkg::ADDR_SEQ_CFG:    panel_seq_cfg    <= wb_dat_i[7:0];
				panel_pkg::ADDR_POWER_CTRL: panel_power_ctrl <= wb_dat_i[7:0];
				panel_pkg::ADDR_MODE:       mode_reg         <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// display enable write is dropped while a hardware sequence runs
	always_ff @(posedge clk_i) begin
		if (rst_i)
			panel_display_ctrl <= panel_pkg::RST_BYTE;
		else if (wr && wb_adr_i == panel_pkg::ADDR_DISPLAY && !busy)
			panel_display_ctrl <= wb_dat_i[7:0];
	end

	// step is loaded by software before expansion
	always_ff @(posedge clk_i) begin
		if (rst_i)
			line_dup_step <= panel_pkg::RST_DUP;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == panel_pkg::ADDR_DUP_STEP) begin
			if (wb_sel_i[0])
				line_dup_step[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				line_dup_step[9:8] <= wb_dat_i[9:8];
		end
	end

	always_comb begin
		case (wb_adr_i)
			panel_pkg::ADDR_DITHER_CFG: next_rdata = {24'h000000, panel_dither_cfg};
			panel_pkg::ADDR_SEQ_TIMING: next_rdata = {24'h000000, panel_seq_timing};
			panel_pkg::ADDR_SEQ_CFG:    next_rdata = {24'h000000, panel_seq_cfg};
			panel_pkg::ADDR_DISPLAY:    next_rdata = {24'h000000, panel_display_ctrl};
			panel_pkg::ADDR_POWER_CTRL: next_rdata = {24'h000000, panel_power_ctrl};
			panel_pkg::ADDR_DUP_STEP:   next_rdata = {22'h0, line_dup_step};
			panel_pkg::ADDR_MODE:       next_rdata = {24'h000000, mode_reg};
			panel_pkg::ADDR_STATUS:     next_rdata = {26'h0, dup_line_o, busy, panel_enable_out_o,
				panel_bias_power_en_o, ctl_data_en, panel_logic_power_en_o};
			default:                    next_rdata = 32'h00000000;
		endcase
	end

	// one-cycle wait state; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= next_rdata;
		end
	end

	// ****************************************
	// vsync synchroniser and frame tick
	// ****************************************
	logic vs_meta;
	logic vs_sync;
	logic vs_last;
	logic frame_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vs_meta <= 1'b0;
			vs_sync <= 1'b0;
			vs_last <= 1'b0;
		end else begin
			vs_meta <= vsync_i;
			vs_sync <= vs_meta;
			vs_last <= vs_sync;
		end
	end

	assign frame_tick = vs_sync && !vs_last;

	// frame count for frame rate modulation
	logic [2:0] frame_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			frame_cnt <= 3'h0;
		else if (frame_tick)
			frame_cnt <= frame_cnt + 3'h1;
	end

	// ****************************************
	// vertical line duplication
	// ****************************************
	logic [panel_pkg::SUM_W-1:0] dup_sum;
	logic [panel_pkg::SUM_W-1:0] next_sum;

	assign next_sum = dup_sum + {1'b0, line_dup_step};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dup_sum    <= '0;
			dup_line_o <= 1'b0;
		end else if ((text_mode_i && row_end_i) || (!text_mode_i && frame_tick)) begin
			dup_sum    <= '0;
			dup_line_o <= 1'b0;
		end else if (line_end_i) begin
			dup_sum    <= next_sum;
			dup_line_o <= next_sum < dup_sum;
		end
	end

	// ****************************************
	// dithering and power sequencing
	// ****************************************
	panel_pkg::rgb_s dith_a;
	panel_pkg::rgb_s dith_b;
	logic            stn;

	assign stn = (mode_reg[2:0] == panel_pkg::MODE_DSTN16) || (mode_reg[2:0] == panel_pkg::MODE_DSTN24);
	assign disp_req = panel_display_ctrl[panel_pkg::DISP_EN_BIT];

	panel_dither u_dither_a (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pix_en_i   (pix_en_i),
		.stn_i      (stn),
		.dstn_32_i  (panel_dither_cfg[panel_pkg::DSTN_LEVELS_BIT]),
		.tft_mode_i (panel_dither_cfg[panel_pkg::TFT_DITH_LO +: 2]),
		.frame_i    (frame_cnt),
		.x_i        (x_i),
		.y_i        (y_i),
		.pix_i      (pix_a_i),
		.pix_o      (dith_a)
	);

	panel_dither u_dither_b (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pix_en_i   (pix_en_i),
		.stn_i      (stn),
		.dstn_32_i  (panel_dither_cfg[panel_pkg::DSTN_LEVELS_BIT]),
		.tft_mode_i (panel_dither_cfg[panel_pkg::TFT_DITH_LO +: 2]),
		.frame_i    (frame_cnt + 3'h1),
		.x_i        (x_i + 5'h01),
		.y_i        (y_i),
		.pix_i      (pix_b_i),
		.pix_o      (dith_b)
	);

	panel_power_seq u_seq (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.hw_mode_i              (panel_seq_cfg[panel_pkg::SEQ_HW_BIT]),
		.disp_en_i              (disp_req),
		.interval_i             (panel_seq_timing[panel_pkg::SEQ_TIME_LO +: 2]),
		.sw_power_i             (panel_power_ctrl[3:0]),
		.frame_tick_i           (frame_tick),
		.panel_logic_power_en_o (panel_logic_power_en_o),
		.ctl_data_en_o          (ctl_data_en),
		.panel_bias_power_en_o  (panel_bias_power_en_o),
		.panel_enable_out_o     (panel_enable_out_o),
		.busy_o                 (busy)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			backlight_ctrl_o <= 1'b0;
		else
			backlight_ctrl_o <= panel_power_ctrl[panel_pkg::PWR_BKLGT_BIT];
	end

	// ****************************************
	// pin mapping
	// ****************************************
	logic [35:0] next_data;

	always_comb begin
		next_data = 36'h000000000;
		case (mode_reg[2:0])
			panel_pkg::MODE_TFT_1P:
				next_data[23:0] = {dith_a.red, dith_a.green, dith_a.blue};
			panel_pkg::MODE_TFT_2P12, panel_pkg::MODE_TFT_2P18: begin
				next_data[23:0] = {dith_b.red[7:4], dith_a.red[7:4], dith_b.green[7:4], dith_a.green[7:4],
					dith_b.blue[7:4], dith_a.blue[7:4]};
				if (mode_reg[2:0] == panel_pkg::MODE_TFT_2P18) begin
					next_data[23:0] = {dith_b.red[5:2], dith_a.red[5:2], dith_b.green[5:2], dith_a.green[5:2],
						dith_b.blue[5:2], dith_a.blue[5:2]};
					next_data[35:24] = {dith_b.red[7:6], dith_a.red[7:6], dith_b.green[7:6], dith_a.green[7:6],
						dith_b.blue[7:6], dith_a.blue[7:6]};
				end
			end
			panel_pkg::MODE_DSTN16:
				next_data[23:0] = {4'h0, dith_a.red[7:4], dith_a.green[7:4], 4'h0, dith_b.red[7:4], dith_b.green[7:4]};
			panel_pkg::MODE_DSTN24:
				next_data[23:0] = {dith_a.red[7:4], dith_a.green[7:4], dith_a.blue[7:4],
					dith_b.red[7:4], dith_b.green[7:4], dith_b.blue[7:4]};
			default: next_data = 36'h000000000;
		endcase
	end

	// data is held low until control/data power is up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			panel_o <= '0;
		end else begin
			panel_o.data  <= ctl_data_en ? next_data : 36'h000000000;
			panel_o.hsync <= ctl_data_en && hsync_i;
			panel_o.vsync <= ctl_data_en && vsync_i;
			panel_o.valid <= ctl_data_en && active_i && !stn;
		end
	end

	// ****************************************
	// clocks to panel and transmitter
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i)
			panel_shift_clock_o <= 1'b0;
		else
			panel_shift_clock_o <= ctl_data_en && pix_en_i;
	end

	// stn clocks the transmitter from the serializer clock
	assign xmit_clock_o = stn ? serializer_clock_i : panel_shift_clock_o;

endmodule

// File: verif/panel_monitor.sv
// checker for the bus handshake and panel power behaviour at the top ports
`timescale 1ns/1ns
module panel_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        panel_enable_out_o,
	input wire logic        panel_logic_power_en_o,
	input wire logic        panel_bias_power_en_o,
	input wire logic        backlight_ctrl_o
);
	// ****************************************
	// helper state
	// ****************************************
	logic       wr_any;
	logic       hw_mode;
	logic [2:0] pwr_hist;
	assign wr_any = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_hist <= 3'h0;
		end else begin
			pwr_hist <= {pwr_hist[1:0], wr_any && wb_adr_i == panel_pkg::ADDR_POWER_CTRL};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hw_mode <= 1'b0;
		end else if (wr_any && wb_ack_o && wb_adr_i == panel_pkg::ADDR_SEQ_CFG) begin
			hw_mode <= wb_dat_i[panel_pkg::SEQ_HW_BIT];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_bias_up;
		hw_mode && $rose(panel_bias_power_en_o);
	endsequence
	property p_ack_next;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_reset_quiet;
		$fell(rst_i) |-> !(wb_ack_o || panel_enable_out_o || panel_logic_power_en_o || panel_bias_power_en_o);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
	property p_backlight_src;
		$changed(backlight_ctrl_o) |-> pwr_hist != 3'h0;
	endproperty
	a_backlight_src: assert property (p_backlight_src) else $error("backlight moved without write");
	property p_sw_follow;
		!hw_mode && $changed(panel_logic_power_en_o) |-> pwr_hist != 3'h0;
	endproperty
	a_sw_follow: assert property (p_sw_follow) else $error("logic power moved without write");
	property p_hw_on_order;
		s_bias_up |-> panel_enable_out_o && !panel_logic_power_en_o;
	endproperty
	a_hw_on_order: assert property (p_hw_on_order) else $error("bias before panel enable");
	property p_hw_gap;
		s_bias_up |-> $past(panel_enable_out_o, 8);
	endproperty
	a_hw_gap: assert property (p_hw_gap) else $error("bias followed enable too soon");
	property p_hw_logic_last;
		hw_mode && $rose(panel_logic_power_en_o) |-> panel_bias_power_en_o && panel_enable_out_o;
	endproperty
	a_hw_logic_last: assert property (p_hw_logic_last) else $error("logic power out of order");
	property p_hw_off_order;
		hw_mode && $fell(panel_enable_out_o) |-> !panel_bias_power_en_o && !panel_logic_power_en_o;
	endproperty
	a_hw_off_order: assert property (p_hw_off_order) else $error("panel enable dropped early");
endmodule

bind flat_panel_power_dither_iface panel_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .panel_enable_out_o, .panel_logic_power_en_o, .panel_bias_power_en_o,
	.backlight_ctrl_o);

// File: verif/panel_sink.sv
// panel side model: takes pixel words while the shift clock runs
`timescale 1ns/1ns
module panel_sink (
	input  wire logic                  clk_i,
	input  wire panel_pkg::panel_bus_s panel_i,
	input  wire logic                  shift_i,
	output logic [35:0]                word_o
);
	// ****************************************
	// capture
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (shift_i && panel_i.valid) begin
			word_o <= panel_i.data;
		end
	end
endmodule

// File: verif/tb_top.sv
// testbench: registers, line duplication, power sequencing and pixel mapping
`timescale 1ns/1ns
module tb_top;
	localparam int FRAME = 16;
	localparam int STEP = 1024 * 700 / 1024;
	logic                  clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]            wb_adr_i;
	logic [3:0]            wb_sel_i;
	logic [31:0]           wb_dat_i, wb_dat_o;
	logic                  pix_en_i, hsync_i, vsync_i, active_i, line_end_i, row_end_i, text_mode_i;
	logic [4:0]            x_i, y_i;
	logic                  serializer_clock_i, panel_shift_clock_o, xmit_clock_o, dup_line_o;
	logic                  panel_enable_out_o, panel_logic_power_en_o, panel_bias_power_en_o, backlight_ctrl_o;
	panel_pkg::rgb_s       pix_a_i, pix_b_i;
	panel_pkg::panel_bus_s panel_o;
	logic [35:0]           word;
	logic [5:0]            obs;
	logic                  frame_run, dup_prev;
	int                    fcnt = 0, cyc_n = 0, rises = 0, bad_count = 0, n_tests = 0;
	assign obs = {dup_line_o, backlight_ctrl_o, panel_enable_out_o, panel_bias_power_en_o, panel_shift_clock_o,
		panel_logic_power_en_o};
	flat_panel_power_dither_iface u_dut (.*);
	panel_sink u_sink (.clk_i(clk_i), .panel_i(panel_o), .shift_i(panel_shift_clock_o), .word_o(word));
	// ****************************************
	// clock, frames, counters
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
		vsync_i <= frame_run && fcnt < 2;
		cyc_n <= cyc_n + 1;
		dup_prev <= dup_line_o;
		if (dup_line_o === 1'b1 && dup_prev !== 1'b1) rises <= rises + 1;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic summarize;
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
		int n;
		n = 0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hF, dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
		if (n >= 50) begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic wait_obs(input int idx, input logic v, output int t);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (obs[idx] !== v && n < 4000);
		t = cyc_n;
		@(posedge clk_i);
		if (n >= 4000) begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic pwr_steps(input logic [4:0] seq [4]);
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, panel_pkg::ADDR_POWER_CTRL, {27'h0, seq[i]}, d);
			repeat (FRAME) @(posedge clk_i);
			check({31'h0, obs[4:0]}, {31'h0, seq[i]});
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0, d);
			check({4'h0, d}, 36'h0);
		end
		wb(1'b1, 8'h40, 32'hFF, d);
		wb(1'b0, 8'h40, 32'h0, d);
		check({4'h0, d}, 36'h0);
		wb(1'b1, panel_pkg::ADDR_DITHER_CFG, 32'h20, d);
		wb(1'b0, panel_pkg::ADDR_DITHER_CFG, 32'h0, d);
		check({4'h0, d}, 36'h20);
	endtask
	task automatic t_dup;
		int sum, exp, r0;
		logic [31:0] d;
		sum = 0;
		exp = 0;
		frame_run <= 1'b0;
		text_mode_i <= 1'b1;
		wb(1'b1, panel_pkg::ADDR_DUP_STEP, 32'(STEP), d);
		wb(1'b0, panel_pkg::ADDR_DUP_STEP, 32'h0, d);
		check({4'h0, d}, 36'(STEP));
		row_end_i <= 1'b1;
		@(posedge clk_i);
		row_end_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		r0 = rises;
		for (int l = 0; l < 30; l++) begin
			sum += STEP;
			if (sum >= 2048) exp++;
			sum = (l % 10 == 9) ? 0 : sum % 2048;
			line_end_i <= 1'b1;
			@(posedge clk_i);
			line_end_i <= 1'b0;
			row_end_i <= (l % 10 == 9);
			@(posedge clk_i);
			row_end_i <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
		check(36'(rises - r0), 36'(exp));
		text_mode_i <= 1'b0;
		frame_run <= 1'b1;
	endtask
	task automatic t_hw;
		int t0, t1, t3;
		logic [31:0] d;
		wb(1'b1, panel_pkg::ADDR_SEQ_CFG, 32'h80, d);
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, panel_pkg::ADDR_SEQ_TIMING, 32'(c << 2), d);
			wb(1'b1, panel_pkg::ADDR_DISPLAY, 32'h1, d);
			if (c == 3) wb(1'b1, panel_pkg::ADDR_DISPLAY, 32'h0, d);
			wait_obs(3, 1'b1, t0);
			wait_obs(2, 1'b1, t1);
			wait_obs(0, 1'b1, t3);
			check(36'(t1 - t0), 36'(FRAME << c));
			check(36'(t3 - t1), 36'(2 * FRAME << c));
			check(36'(obs[4]), 36'h0);
			wb(1'b1, panel_pkg::ADDR_DISPLAY, 32'h0, d);
			wait_obs(0, 1'b0, t0);
			wait_obs(2, 1'b0, t1);
			wait_obs(3, 1'b0, t3);
			check(36'(t3 - t1), 36'(FRAME << c));
		end
		wb(1'b1, panel_pkg::ADDR_SEQ_CFG, 32'h0, d);
	endtask
	task automatic t_sw(input logic on);
		logic [31:0] d;
		if (on) begin
			wb(1'b1, panel_pkg::ADDR_DISPLAY, 32'h1, d);
			pwr_steps('{5'h01, 5'h03, 5'h07, 5'h1F});
		end else begin
			pwr_steps('{5'h07, 5'h03, 5'h01, 5'h00});
			wb(1'b1, panel_pkg::ADDR_DISPLAY, 32'h0, d);
		end
	endtask
	task automatic t_pix;
		logic [31:0] d;
		panel_pkg::rgb_s a, b;
		a = 24'hA53CE1;
		b = 24'h5AC31E;
		pix_a_i <= a;
		pix_b_i <= b;
		hsync_i <= 1'b1;
		wb(1'b1, panel_pkg::ADDR_DITHER_CFG, 32'h80, d);
		for (int m = 0; m < 3; m++) begin
			wb(1'b1, panel_pkg::ADDR_MODE, 32'(m), d);
			repeat (8) @(posedge clk_i);
			if (m == 0) check({12'h0, word[23:0]}, {12'h0, a});
			else if (m == 1) check({12'h0, word[23:0]}, {12'h0, b.red[7:4], a.red[7:4], b.green[7:4],
				a.green[7:4], b.blue[7:4], a.blue[7:4]});
			else check(word, {b.red[7:6], a.red[7:6], b.green[7:6], a.green[7:6], b.blue[7:6], a.blue[7:6],
				b.red[5:2], a.red[5:2], b.green[5:2], a.green[5:2], b.blue[5:2], a.blue[5:2]});
		end
		check({34'h0, panel_o.hsync, panel_o.valid}, 36'h3);
		hsync_i <= 1'b0;
		wb(1'b1, panel_pkg::ADDR_MODE, 32'h3, d);
		for (int v = 0; v < 2; v++) begin
			serializer_clock_i <= 1'(v);
			@(posedge clk_i);
			check({35'h0, xmit_clock_o}, {35'h0, 1'(v)});
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_i, pix_en_i, active_i, frame_run} = 4'hF;
		{wb_cyc_i, wb_stb_i, wb_we_i, hsync_i, line_end_i, row_end_i, text_mode_i, serializer_clock_i} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, x_i, y_i, pix_a_i, pix_b_i} = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_dup();
		t_hw();
		t_sw(1'b1);
		t_pix();
		t_sw(1'b0);
		summarize();
	end
endmodule
